// *** design/alu_branch_pkg.sv ***
// Package: operation codes, widths and constants of the execute unit
package alu_branch_pkg;

    localparam int DATA_W        = 32;
    localparam int SIGN_BIT      = 31;
    localparam int IMM_W         = 16;
    localparam int OFFSET_W      = 16;
    localparam int CC_W          = 3;
    localparam int SEL_W         = 5;
    localparam int REG_IDX_W     = 5;
    localparam int COUNT_W       = 6;
    localparam logic [4:0]  LINK_REG_IDX = 5'h1f;
    localparam logic [31:0] LINK_STEP    = 32'h0000_0008;
    localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
    localparam logic [4:0]  RESET_IDX    = 5'h00;

    typedef enum logic [5:0] {
        OP_NOP,
        OP_SIGNED_REG_ADD,
        OP_UNSIGNED_REG_ADD,
        OP_SIGNED_IMM_ADD,
        OP_UNSIGNED_IMM_ADD,
        OP_PC_RELATIVE_IMM_ADD,
        OP_AND,
        OP_BITWISE_AND_IMM,
        OP_BRANCH_EQUAL,
        OP_BRANCH_EQUAL_LIKELY,
        OP_BRANCH_NOT_EQUAL,
        OP_BRANCH_NOT_EQUAL_LIKELY,
        OP_BRANCH_GE_ZERO,
        OP_BRANCH_GE_ZERO_LIKELY,
        OP_BRANCH_GE_ZERO_LINK,
        OP_BRANCH_GE_ZERO_LINK_LIKELY,
        OP_BRANCH_GT_ZERO,
        OP_BRANCH_GT_ZERO_LIKELY,
        OP_BRANCH_LE_ZERO,
        OP_BRANCH_LE_ZERO_LIKELY,
        OP_BRANCH_LT_ZERO,
        OP_BRANCH_LT_ZERO_LIKELY,
        OP_BRANCH_LT_ZERO_LINK,
        OP_BRANCH_LT_ZERO_LINK_LIKELY,
        OP_BRANCH_COPROC_FALSE,
        OP_BRANCH_COPROC_FALSE_LIKELY,
        OP_BRANCH_COPROC_TRUE,
        OP_BRANCH_COPROC_TRUE_LIKELY,
        OP_MOVE_CONTROL_FROM_COPROC,
        OP_MOVE_CONTROL_TO_COPROC,
        OP_COPROC_GENERIC_OPERATION,
        OP_COUNT_LEADING_ONES,
        OP_COUNT_LEADING_ZEROS,
        OP_BREAKPOINT
    } op_type;

    typedef enum {
        ST_IDLE,
        ST_WAIT_COPROC
    } state_type;

endpackage : alu_branch_pkg

// *** design/integer_alu_branch_unit.sv ***
// Execute unit: integer add/AND, conditional branches, count-leading, coprocessor moves
//
// How it works
// - Register-register and register-immediate adds exist in signed and unsigned form, results going to the destination or second-source slot.
// - In compressed mode only, an unsigned immediate is added to the program counter and written to the target register.
// - AND of two registers, and AND with the immediate zero-extended by 16 zero bits.
// - Equal branches take when both sources match, not-equal branches when they differ, each in normal and likely form.
// - Sign branches decide from bit 31 and a zero test of the first source.
// - Link branches always write program counter plus 8 into register 31, taken or not.
// - Likely branches nullify the following instruction when the condition is false.
// - A taken branch adds the signed offset to the program counter to give the next fetch address.
// - Coprocessor branches test the condition bit picked by the select field, false form on 0 and true form on 1.
// - Likely coprocessor branches nullify the following instruction when the condition does not match.
// - Move-control-from reads the selected coprocessor control word into the target register.
// - Move-control-to sends the target register value to the coprocessor for the selected control word.
// - Generic coprocessor operations are handed to the coprocessor unchanged.
// - Coprocessor data is 32 bits, issued one at a time in order, with at most one return outstanding.
`timescale 1ns/1ps
`default_nettype none

module integer_alu_branch_unit (
    // Clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RST_B,
    // Issue
    input  wire logic                   ISSUE_VALID,
    output logic                        ISSUE_READY,
    input  wire alu_branch_pkg::op_type ISSUE_OP,
    input  wire logic [31:0]            SOURCE_REG_A,
    input  wire logic [31:0]            SOURCE_REG_B,
    input  wire logic [15:0]            IMMEDIATE,
    input  wire logic [31:0]            PC,
    input  wire logic                   COMPRESSED_MODE,
    input  wire logic [4:0]             DEST_IDX,
    input  wire logic [4:0]             TARGET_IDX,
    input  wire logic [2:0]             COPROC_CONDITION_SELECT,
    input  wire logic [4:0]             COPROC_CONTROL_SELECT,
    input  wire logic [31:0]            COPROC_INSTR,
    // Result
    output logic                        RESULT_VALID,
    output logic                        WRITE_EN,
    output logic [4:0]                  WRITE_IDX,
    output logic [31:0]                 WRITE_DATA,
    output logic                        BRANCH_TAKEN,
    output logic [31:0]                 BRANCH_TARGET,
    output logic                        NULLIFY_NEXT,
    output logic                        BREAK_EXCEPTION,
    output logic                        ILLEGAL_OP,
    // Coprocessor condition
    input  wire logic [7:0]             COPROC_CONDITION,
    // Coprocessor requests
    output logic                        COP_REQ_VALID,
    input  wire logic                   COP_REQ_READY,
    output logic [1:0]                  COP_REQ_KIND,
    output logic [4:0]                  COP_REQ_SELECT,
    output logic [31:0]                 COP_REQ_DATA,
    // Coprocessor return
    input  wire logic                   COP_RET_VALID,
    input  wire logic [31:0]            COP_RET_DATA
);

    // ==========================================================
    // State
    typedef struct packed {
        alu_branch_pkg::state_type st;
        logic                      res_valid;
        logic                      wr_en;
        logic [4:0]                wr_idx;
        logic [31:0]               wr_data;
        logic                      br_taken;
        logic [31:0]               br_target;
        logic                      nullify;
        logic                      brk;
        logic                      illegal;
        logic                      req_valid;
        logic [1:0]                req_kind;
        logic [4:0]                req_sel;
        logic [31:0]               req_data;
        logic [4:0]                ret_idx;
    } state_t_type;

    state_t_type s_r;
    state_t_type s_nxt;

    // ==========================================================
    // Datapath helpers
    logic [31:0] imm_sext;
    logic [31:0] imm_zext;
    logic [31:0] off_word;
    logic [31:0] sum_rr;
    logic [31:0] sum_ri;
    logic [31:0] sum_pc;
    logic [31:0] link_addr;
    logic [31:0] target;
    logic        src_zero;
    logic        src_neg;
    logic        cop_bit;
    logic [5:0]  lead_ones;
    logic [5:0]  lead_zeros;

    assign imm_sext  = {{16{IMMEDIATE[15]}}, IMMEDIATE};
    assign imm_zext  = {16'h0000, IMMEDIATE};
    assign off_word  = {{14{IMMEDIATE[15]}}, IMMEDIATE, 2'b00};
    assign sum_rr    = SOURCE_REG_A + SOURCE_REG_B;
    assign sum_ri    = SOURCE_REG_A + imm_sext;
    assign sum_pc    = PC + imm_zext;
    assign link_addr = PC + alu_branch_pkg::LINK_STEP;
    assign target    = PC + off_word;
    assign src_zero  = (SOURCE_REG_A == alu_branch_pkg::RESET_WORD);
    assign src_neg   = SOURCE_REG_A[alu_branch_pkg::SIGN_BIT];
    assign cop_bit   = COPROC_CONDITION[COPROC_CONDITION_SELECT];

    // Leading-run count; loop walks all 32 bits and the run flag drops at the first mismatch, so 32 falls out naturally
    always_comb begin
        logic run1;
        logic run0;
        run1       = 1'b1;
        run0       = 1'b1;
        lead_ones  = 6'h00;
        lead_zeros = 6'h00;
        for (int i = 31; i >= 0; i--) begin
            run1 = run1 & SOURCE_REG_A[i];
            run0 = run0 & ~SOURCE_REG_A[i];
            lead_ones  = lead_ones + {5'h00, run1};
            lead_zeros = lead_zeros + {5'h00, run0};
        end
    end

    // ==========================================================
    // Handshake
    // Only one coprocessor return may be outstanding, so issue stalls while waiting
    assign ISSUE_READY = (s_r.st == alu_branch_pkg::ST_IDLE)
                         && !(s_r.req_valid && !COP_REQ_READY);

    // ==========================================================
    // Next state
    always_comb begin
        logic cond;
        logic likely;
        logic is_br;
        logic link;
        cond   = 1'b0;
        likely = 1'b0;
        is_br  = 1'b0;
        link   = 1'b0;
        s_nxt  = s_r;
        s_nxt.res_valid = 1'b0;
        s_nxt.wr_en     = 1'b0;
        s_nxt.br_taken  = 1'b0;
        s_nxt.nullify   = 1'b0;
        s_nxt.brk       = 1'b0;
        s_nxt.illegal   = 1'b0;
        if (s_r.req_valid && COP_REQ_READY) begin
            s_nxt.req_valid = 1'b0;
        end
        case (s_r.st)
            alu_branch_pkg::ST_IDLE: begin
                if (ISSUE_VALID && ISSUE_READY) begin
                    s_nxt.res_valid = 1'b1;
                    s_nxt.wr_idx    = DEST_IDX;
                    case (ISSUE_OP)
                        alu_branch_pkg::OP_NOP: begin
                        end
                        alu_branch_pkg::OP_SIGNED_REG_ADD,
                        alu_branch_pkg::OP_UNSIGNED_REG_ADD: begin
                            s_nxt.wr_en   = 1'b1;
                            s_nxt.wr_data = sum_rr;
                        end
                        alu_branch_pkg::OP_SIGNED_IMM_ADD,
                        alu_branch_pkg::OP_UNSIGNED_IMM_ADD: begin
                            s_nxt.wr_en   = 1'b1;
                            s_nxt.wr_idx  = TARGET_IDX;
                            s_nxt.wr_data = sum_ri;
                        end
                        alu_branch_pkg::OP_PC_RELATIVE_IMM_ADD: begin
                            // Not defined outside compressed mode
                            s_nxt.wr_en   = COMPRESSED_MODE;
                            s_nxt.illegal = !COMPRESSED_MODE;
                            s_nxt.wr_idx  = TARGET_IDX;
                            s_nxt.wr_data = sum_pc;
                        end
                        alu_branch_pkg::OP_AND: begin
                            s_nxt.wr_en   = 1'b1;
                            s_nxt.wr_data = SOURCE_REG_A & SOURCE_REG_B;
                        end
                        alu_branch_pkg::OP_BITWISE_AND_IMM: begin
                            s_nxt.wr_en   = 1'b1;
                            s_nxt.wr_idx  = TARGET_IDX;
                            s_nxt.wr_data = SOURCE_REG_A & imm_zext;
                        end
                        alu_branch_pkg::OP_BRANCH_EQUAL,
                        alu_branch_pkg::OP_BRANCH_EQUAL_LIKELY: begin
                            is_br  = 1'b1;
                            cond   = (SOURCE_REG_A == SOURCE_REG_B);
                            likely = (ISSUE_OP == alu_branch_pkg::OP_BRANCH_EQUAL_LIKELY);
                        end
                        alu_branch_pkg::OP_BRANCH_NOT_EQUAL,
                        alu_branch_pkg::OP_BRANCH_NOT_EQUAL_LIKELY: begin
                            is_br  = 1'b1;
                            cond   = (SOURCE_REG_A != SOURCE_REG_B);
                            likely = (ISSUE_OP == alu_branch_pkg::OP_BRANCH_NOT_EQUAL_LIKELY);
                        end
                        alu_branch_pkg::OP_BRANCH_GE_ZERO,
                        alu_branch_pkg::OP_BRANCH_GE_ZERO_LIKELY,
                        alu_branch_pkg::OP_BRANCH_GE_ZERO_LINK,
                        alu_branch_pkg::OP_BRANCH_GE_ZERO_LINK_LIKELY: begin
                            is_br  = 1'b1;
                            cond   = !src_neg;
                            likely = (ISSUE_OP == alu_branch_pkg::OP_BRANCH_GE_ZERO_LIKELY)
                                  || (ISSUE_OP == alu_branch_pkg::OP_BRANCH_GE_ZERO_LINK_LIKELY);
                            link   = (ISSUE_OP == alu_branch_pkg::OP_BRANCH_GE_ZERO_LINK)
                                  || (ISSUE_OP == alu_branch_pkg::OP_BRANCH_GE_ZERO_LINK_LIKELY);
                        end
                        alu_branch_pkg::OP_BRANCH_GT_ZERO,
                        alu_branch_pkg::OP_BRANCH_GT_ZERO_LIKELY: begin
                            is_br  = 1'b1;
                            cond   = !src_neg && !src_zero;
                            likely = (ISSUE_OP == alu_branch_pkg::OP_BRANCH_GT_ZERO_LIKELY);
                        end
                        alu_branch_pkg::OP_BRANCH_LE_ZERO,
                        alu_branch_pkg::OP_BRANCH_LE_ZERO_LIKELY: begin
                            is_br  = 1'b1;
                            cond   = src_neg || src_zero;
                            likely = (ISSUE_OP == alu_branch_pkg::OP_BRANCH_LE_ZERO_LIKELY);
                        end
                        alu_branch_pkg::OP_BRANCH_LT_ZERO,
                        alu_branch_pkg::OP_BRANCH_LT_ZERO_LIKELY,
                        alu_branch_pkg::OP_BRANCH_LT_ZERO_LINK,
                        alu_branch_pkg::OP_BRANCH_LT_ZERO_LINK_LIKELY: begin
                            is_br  = 1'b1;
                            cond   = src_neg;
                            likely = (ISSUE_OP == alu_branch_pkg::OP_BRANCH_LT_ZERO_LIKELY)
                                  || (ISSUE_OP == alu_branch_pkg::OP_BRANCH_LT_ZERO_LINK_LIKELY);
                            link   = (ISSUE_OP == alu_branch_pkg::OP_BRANCH_LT_ZERO_LINK)
                                  || (ISSUE_OP == alu_branch_pkg::OP_BRANCH_LT_ZERO_LINK_LIKELY);
                        end
                        alu_branch_pkg::OP_BRANCH_COPROC_FALSE,
                        alu_branch_pkg::OP_BRANCH_COPROC_FALSE_LIKELY: begin
                            is_br  = 1'b1;
                            cond   = !cop_bit;
                            likely = (ISSUE_OP == alu_branch_pkg::OP_BRANCH_COPROC_FALSE_LIKELY);
                        end
                        alu_branch_pkg::OP_BRANCH_COPROC_TRUE,
                        alu_branch_pkg::OP_BRANCH_COPROC_TRUE_LIKELY: begin
                            is_br  = 1'b1;
                            cond   = cop_bit;
                            likely = (ISSUE_OP == alu_branch_pkg::OP_BRANCH_COPROC_TRUE_LIKELY);
                        end
                        alu_branch_pkg::OP_MOVE_CONTROL_FROM_COPROC: begin
                            // Result is posted when the control word returns
                            s_nxt.res_valid = 1'b0;
                            s_nxt.req_valid = 1'b1;
                            s_nxt.req_kind  = 2'h0;
                            s_nxt.req_sel   = COPROC_CONTROL_SELECT;
                            s_nxt.req_data  = alu_branch_pkg::RESET_WORD;
                            s_nxt.ret_idx   = TARGET_IDX;
                            s_nxt.st        = alu_branch_pkg::ST_WAIT_COPROC;
                        end
                        alu_branch_pkg::OP_MOVE_CONTROL_TO_COPROC: begin
                            s_nxt.req_valid = 1'b1;
                            s_nxt.req_kind  = 2'h1;
                            s_nxt.req_sel   = COPROC_CONTROL_SELECT;
                            s_nxt.req_data  = SOURCE_REG_B;
                        end
                        alu_branch_pkg::OP_COPROC_GENERIC_OPERATION: begin
                            s_nxt.req_valid = 1'b1;
                            s_nxt.req_kind  = 2'h2;
                            s_nxt.req_sel   = alu_branch_pkg::RESET_IDX;
                            s_nxt.req_data  = COPROC_INSTR;
                        end
                        alu_branch_pkg::OP_COUNT_LEADING_ONES: begin
                            s_nxt.wr_en   = 1'b1;
                            s_nxt.wr_data = {26'h0, lead_ones};
                        end
                        alu_branch_pkg::OP_COUNT_LEADING_ZEROS: begin
                            s_nxt.wr_en   = 1'b1;
                            s_nxt.wr_data = {26'h0, lead_zeros};
                        end
                        alu_branch_pkg::OP_BREAKPOINT: begin
                            s_nxt.brk = 1'b1;
                        end
                        default: begin
                            s_nxt.illegal = 1'b1;
                        end
                    endcase
                    if (is_br) begin
                        s_nxt.br_taken  = cond;
                        s_nxt.br_target = target;
                        s_nxt.nullify   = likely && !cond;
                        if (link) begin
                            s_nxt.wr_en   = 1'b1;
                            s_nxt.wr_idx  = alu_branch_pkg::LINK_REG_IDX;
                            s_nxt.wr_data = link_addr;
                        end
                    end
                end
            end
            alu_branch_pkg::ST_WAIT_COPROC: begin
                if (COP_RET_VALID) begin
                    s_nxt.res_valid = 1'b1;
                    s_nxt.wr_en     = 1'b1;
                    s_nxt.wr_idx    = s_r.ret_idx;
                    s_nxt.wr_data   = COP_RET_DATA;
                    s_nxt.st        = alu_branch_pkg::ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = alu_branch_pkg::ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            s_r             <= '0;
            s_r.st          <= alu_branch_pkg::ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign RESULT_VALID    = s_r.res_valid;
    assign WRITE_EN        = s_r.wr_en;
    assign WRITE_IDX       = s_r.wr_idx;
    assign WRITE_DATA      = s_r.wr_data;
    assign BRANCH_TAKEN    = s_r.br_taken;
    assign BRANCH_TARGET   = s_r.br_target;
    assign NULLIFY_NEXT    = s_r.nullify;
    assign BREAK_EXCEPTION = s_r.brk;
    assign ILLEGAL_OP      = s_r.illegal;
    assign COP_REQ_VALID   = s_r.req_valid;
    assign COP_REQ_KIND    = s_r.req_kind;
    assign COP_REQ_SELECT  = s_r.req_sel;
    assign COP_REQ_DATA    = s_r.req_data;

endmodule : integer_alu_branch_unit

`default_nettype wire

// *** testbench/alu_branch_properties.sv ***
// Checker: port-level properties of the execute unit
`timescale 1ns/1ps
`default_nettype none
module alu_branch_properties (
    // Clock and reset
    input wire logic                   CLK,
    input wire logic                   RST_B,
    // Issue
    input wire logic                   ISSUE_VALID,
    input wire logic                   ISSUE_READY,
    input wire alu_branch_pkg::op_type ISSUE_OP,
    input wire logic [31:0]            SOURCE_REG_A,
    input wire logic [31:0]            SOURCE_REG_B,
    input wire logic [15:0]            IMMEDIATE,
    input wire logic [31:0]            PC,
    // Result
    input wire logic                   WRITE_EN,
    input wire logic [4:0]             WRITE_IDX,
    input wire logic [31:0]            WRITE_DATA,
    input wire logic                   BRANCH_TAKEN,
    input wire logic [31:0]            BRANCH_TARGET,
    input wire logic                   NULLIFY_NEXT,
    input wire logic                   BREAK_EXCEPTION,
    // Coprocessor requests
    input wire logic                   COP_REQ_VALID,
    input wire logic                   COP_REQ_READY,
    input wire logic [1:0]             COP_REQ_KIND,
    input wire logic [31:0]            COP_REQ_DATA
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    wire logic take = ISSUE_VALID && ISSUE_READY;
    // ========================================
    // Properties
    AST_BREAK: assert property (take && ISSUE_OP == alu_branch_pkg::OP_BREAKPOINT |=> BREAK_EXCEPTION && !WRITE_EN)
        else $error("breakpoint not flagged or wrote a register");
    AST_LINK: assert property (take && ISSUE_OP inside {alu_branch_pkg::OP_BRANCH_GE_ZERO_LINK,
        alu_branch_pkg::OP_BRANCH_LT_ZERO_LINK_LIKELY} |=> WRITE_EN && WRITE_IDX == 5'h1f && WRITE_DATA == $past(PC) + 32'h8)
        else $error("link write wrong");
    AST_EQ_TARGET: assert property (take && ISSUE_OP == alu_branch_pkg::OP_BRANCH_EQUAL && SOURCE_REG_A == SOURCE_REG_B
        |=> BRANCH_TAKEN && BRANCH_TARGET == $past(PC) + {{14{$past(IMMEDIATE[15])}}, $past(IMMEDIATE), 2'b00})
        else $error("equal branch not taken to offset target");
    AST_NE_HELD: assert property (take && ISSUE_OP == alu_branch_pkg::OP_BRANCH_NOT_EQUAL_LIKELY
        && SOURCE_REG_A == SOURCE_REG_B |=> !BRANCH_TAKEN && NULLIFY_NEXT) else $error("not-equal on equal operands");
    AST_SIGN: assert property (take && ISSUE_OP == alu_branch_pkg::OP_BRANCH_GE_ZERO_LIKELY |=>
        BRANCH_TAKEN == !$past(SOURCE_REG_A[31]) && NULLIFY_NEXT == $past(SOURCE_REG_A[31])) else $error("sign branch wrong");
    AST_ADD: assert property (take && ISSUE_OP == alu_branch_pkg::OP_UNSIGNED_REG_ADD |=>
        WRITE_EN && WRITE_DATA == $past(SOURCE_REG_A) + $past(SOURCE_REG_B)) else $error("register add wrong");
    AST_BITWISE_AND_IMM: assert property (take && ISSUE_OP == alu_branch_pkg::OP_BITWISE_AND_IMM |=>
        WRITE_DATA == ($past(SOURCE_REG_A) & {16'h0, $past(IMMEDIATE)})) else $error("immediate and wrong");
    AST_REQ_HOLD: assert property (COP_REQ_VALID && !COP_REQ_READY |=>
        COP_REQ_VALID && $stable(COP_REQ_DATA) && $stable(COP_REQ_KIND)) else $error("stalled request changed");
endmodule : alu_branch_properties
`default_nettype wire

// *** testbench/coproc_model.sv ***
// Partner: behavioural coprocessor with control words, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module coproc_model (
    // Clock, reset and pace
    input wire logic         CLK,
    input wire logic         RST_B,
    input wire logic         SLOW,
    // Requests
    input wire logic         COP_REQ_VALID,
    output logic             COP_REQ_READY,
    input wire logic [1:0]   COP_REQ_KIND,
    input wire logic [4:0]   COP_REQ_SELECT,
    input wire logic [31:0]  COP_REQ_DATA,
    // Return
    output logic             COP_RET_VALID,
    output logic [31:0]      COP_RET_DATA
);
    logic [31:0] ctl_r [32];
    logic [31:0] pend_r;
    logic [2:0]  due_r;
    logic [1:0]  pace_r;
    // Slow pace accepts one cycle in four so that stalls are seen
    assign COP_REQ_READY = COP_REQ_VALID && (!SLOW || pace_r == 2'h3);
    always @(posedge CLK) begin
        pace_r <= pace_r + 2'h1;
        COP_RET_VALID <= due_r == 3'h1;
        // Outside a return the data line flips to the inverse of its last word every cycle
        COP_RET_DATA <= (due_r == 3'h1) ? pend_r : ~COP_RET_DATA;
        due_r <= (due_r != 3'h0) ? due_r - 3'h1 : 3'h0;
        if (COP_REQ_VALID && COP_REQ_READY) begin
            if (COP_REQ_KIND == 2'h1) ctl_r[COP_REQ_SELECT] <= COP_REQ_DATA;
            if (COP_REQ_KIND == 2'h0) pend_r <= ctl_r[COP_REQ_SELECT];
            if (COP_REQ_KIND == 2'h0) due_r <= SLOW ? 3'h5 : 3'h1;
        end
        if (!RST_B) begin
            {pace_r, due_r, COP_RET_VALID, COP_RET_DATA} <= '0;
        end
    end
endmodule : coproc_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Testbench: random sweep of every operation against a reference model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic CLK = 1'b0, RST_B = 1'b0, ISSUE_VALID = 1'b0, COMPRESSED_MODE = 1'b0, SLOW = 1'b0;
    alu_branch_pkg::op_type ISSUE_OP = alu_branch_pkg::OP_NOP;
    logic [31:0] SOURCE_REG_A = 32'h0, SOURCE_REG_B = 32'h0, PC = 32'h0, COPROC_INSTR = 32'h0;
    logic [15:0] IMMEDIATE = 16'h0;
    logic [4:0]  DEST_IDX = 5'h0, TARGET_IDX = 5'h0, COPROC_CONTROL_SELECT = 5'h0, sel = 5'h0;
    logic [2:0]  COPROC_CONDITION_SELECT = 3'h0;
    logic [7:0]  COPROC_CONDITION = 8'h0;
    logic ISSUE_READY, RESULT_VALID, WRITE_EN, BRANCH_TAKEN, NULLIFY_NEXT, BREAK_EXCEPTION, ILLEGAL_OP;
    logic COP_REQ_VALID, COP_REQ_READY, COP_RET_VALID;
    logic [1:0]  COP_REQ_KIND;
    logic [4:0]  WRITE_IDX, COP_REQ_SELECT;
    logic [31:0] WRITE_DATA, BRANCH_TARGET, COP_REQ_DATA, COP_RET_DATA, seed = 32'h0000_004e;
    logic [31:0] ctl [int];
    int fails = 0, total_checks = 0;
    always #2.5 CLK = ~CLK;
    integer_alu_branch_unit dut (.*);
    coproc_model partner (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    // Model leans on the package's operation order: 8..27 are branches, odd ones likely
    task automatic run_op(input int k);
        logic [31:0] a, b, d, t, p;
        logic [15:0] im;
        logic [4:0]  wi;
        logic [5:0]  f;
        logic        c;
        int          n;
        seed = lfsr(seed);
        a = (seed[3:1] == 3'h0) ? {32{seed[0]}} : seed;
        seed = lfsr(seed);
        b = seed[0] ? a : seed;
        im = seed[31:16];
        p = {seed[15:0], a[31:16]};
        if (k inside {[3:5]}) im[15] = 1'b0;  // Sign handling of these immediates is left open
        @(posedge CLK);
        ISSUE_OP <= alu_branch_pkg::op_type'(k);
        {SOURCE_REG_A, SOURCE_REG_B, IMMEDIATE, PC, COPROC_INSTR} <= {a, b, im, p, b};
        {COPROC_CONDITION, COPROC_CONDITION_SELECT, COMPRESSED_MODE} <= seed[15:4];
        {TARGET_IDX, DEST_IDX} <= seed[25:16];
        ISSUE_VALID <= 1'b1;
        f = 6'h30;
        wi = seed[20:16];
        d = 32'h0;
        n = 0;
        t = p + {{14{im[15]}}, im, 2'b00};
        case (k)
            1, 2: d = a + b;
            3, 4: {d, wi} = {a + {16'h0, im}, seed[25:21]};
            5: {d, wi, f} = {p + {16'h0, im}, seed[25:21], seed[4] ? 6'h30 : 6'h21};
            6: d = a & b;
            7: {d, wi} = {a & {16'h0, im}, seed[25:21]};
            28: {d, wi} = {ctl[sel], seed[25:21]};
            29: {ctl[sel], f} = {b, 6'h20};
            0, 30: f = 6'h20;
            31, 32: begin
                while (n < 32 && a[31 - n] == (k == 31)) n++;
                d = 32'(n);
            end
            33: f = 6'h22;
            default: begin
                case ((k - 8) / 2)
                    0: c = a == b;
                    1: c = a != b;
                    2, 3: c = !a[31];
                    4: c = !a[31] && a != 32'h0;
                    5: c = a[31] || a == 32'h0;
                    6, 7: c = a[31];
                    8: c = !seed[8 + seed[7:5]];
                    default: c = seed[8 + seed[7:5]];
                endcase
                f = {2'b10, c, !c && k[0], 2'b00};
                if (k inside {14, 15, 22, 23}) {f[4], wi, d} = {1'b1, 5'h1f, p + 32'h8};
            end
        endcase
        n = 0;
        do begin @(negedge CLK); n++; end while (ISSUE_READY !== 1'b1 && n < 40);
        @(posedge CLK);
        ISSUE_VALID <= 1'b0;
        if (n == 40) fails++;
        if (n == 40) end_sim;
        n = 0;
        do begin @(negedge CLK); n++; end while (RESULT_VALID !== 1'b1 && n < 40);
        if (n == 40) fails++;
        if (n == 40) end_sim;
        chk("flags", {RESULT_VALID, WRITE_EN, BRANCH_TAKEN, NULLIFY_NEXT,
            BREAK_EXCEPTION, ILLEGAL_OP, n == 1 || k == 28}, {f, 1'b1});
        if (f[4]) chk("write", {WRITE_IDX, WRITE_DATA}, {wi, d});
        if (f[3]) chk("target", BRANCH_TARGET, t);
        if (k inside {29, 30}) chk("req", {COP_REQ_VALID, COP_REQ_KIND, COP_REQ_SELECT, COP_REQ_DATA},
            {1'b1, 2'(k - 28), (k == 29) ? sel : 5'h00, b});
    endtask : run_op
    initial begin
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        for (int r = 0; r < 16; r++) begin
            @(posedge CLK);
            SLOW <= r[3];
            sel = seed[9:5];
            COPROC_CONTROL_SELECT <= sel;
            for (int k = 0; k < 34; k++) begin
                if (k == 28) run_op(29);
                run_op(k);
            end
        end
        end_sim;
    end
endmodule : tb_top
bind integer_alu_branch_unit alu_branch_properties props (.*);
`default_nettype wire
